// *** rtl/swcr_top.sv ***
// Sleep/wake configuration registers with serial register access and wake detection.
// Assumes the host drives a mode-0 serial link far slower than clk_in (200 MHz).
`timescale 1ns/1ps
`default_nettype none

module swcr_top (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic spi_clk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	output logic spi_miso_oe_n_out,
	input wire logic fault_status_in,
	input wire logic interrupt_flag_bit_in,
	input wire logic sleep_state_in,
	input wire logic sleep_tick_in,
	input wire logic poll_tick_in,
	input wire logic [7:0] programmable_input_in,
	input wire logic [13:0] ground_switch_input_in,
	output logic wake_out,
	output logic poll_timer_run_out,
	output logic poll_event_out,
	output logic [7:0] poll_current_en_out,
	output logic [7:0] comparator_only_out
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [swcr_pkg::PIN_W-1:0] pins_sync;
	logic sclk_s;
	logic cs_n_s;
	logic mosi_s;
	logic [7:0] prog_s;
	logic [13:0] gnd_s;

	swcr_sync #(
		.W(swcr_pkg::PIN_W),
		.RST(swcr_pkg::PIN_RST)
	) u_sync (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.async_in({spi_clk_in, spi_cs_n_in, spi_mosi_in, programmable_input_in, ground_switch_input_in}),
		.sync_out(pins_sync)
	);

	assign sclk_s = pins_sync[24];
	assign cs_n_s = pins_sync[23];
	assign mosi_s = pins_sync[22];
	assign prog_s = pins_sync[21:14];
	assign gnd_s = pins_sync[13:0];

	// ------------------------------------------------------------
	// Link edge detection
	// ------------------------------------------------------------
	logic sclk_prev_q;
	logic cs_n_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
	assign cs_fall = ~cs_n_s & cs_n_prev_q;
	assign cs_rise = cs_n_s & ~cs_n_prev_q;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sclk_prev_q <= 1'b0;
			cs_n_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			cs_n_prev_q <= cs_n_s;
		end
	end

	// ------------------------------------------------------------
	// Frame shifter
	// ------------------------------------------------------------
	logic [31:0] rx_q;
	logic [31:0] tx_q;
	logic [5:0] bit_cnt_q;
	logic [6:0] last_addr_q;
	logic last_rw_q;
	logic [6:0] rx_addr;
	logic rx_rw;
	logic frame_ok;
	logic wr_en;
	logic [21:0] rd_data;
	logic [31:0] reply;

	assign rx_addr = rx_q[swcr_pkg::ADDR_MSB:swcr_pkg::ADDR_LSB];
	assign rx_rw = rx_q[swcr_pkg::RW_BIT];
	// A frame of any length other than 32 bits is dropped whole
	assign frame_ok = cs_rise && (bit_cnt_q == swcr_pkg::FRAME_BITS_CNT);
	assign wr_en = frame_ok && rx_rw;
	// Reply carries the previous frame's address and rw, then status and data
	assign reply = {last_addr_q, last_rw_q, fault_status_in, interrupt_flag_bit_in, rd_data};

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_q <= 32'h00000000;
			tx_q <= 32'h00000000;
			bit_cnt_q <= 6'h00;
		end else if (cs_fall) begin
			tx_q <= reply;
			bit_cnt_q <= 6'h00;
		end else begin
			if (sclk_rise) begin
				rx_q <= {rx_q[30:0], mosi_s};
				if (bit_cnt_q != swcr_pkg::BIT_CNT_MAX) begin
					bit_cnt_q <= bit_cnt_q + 6'h01;
				end
			end
			if (sclk_fall) begin
				tx_q <= {tx_q[30:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			last_addr_q <= 7'h00;
			last_rw_q <= 1'b0;
		end else if (frame_ok) begin
			last_addr_q <= rx_addr;
			last_rw_q <= rx_rw;
		end
	end

	assign spi_miso_out = tx_q[31];
	assign spi_miso_oe_n_out = cs_n_s;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [7:0] wake_en_prog_q;
	logic [13:0] wake_en_gnd_q;
	logic [7:0] comp_only_prog_q;
	logic wr_wake_prog;
	logic wr_wake_gnd;
	logic wr_comp_prog;

	assign wr_wake_prog = wr_en && (rx_addr == swcr_pkg::ADDR_WAKE_EN_PROG);
	assign wr_wake_gnd = wr_en && (rx_addr == swcr_pkg::ADDR_WAKE_EN_GND);
	assign wr_comp_prog = wr_en && (rx_addr == swcr_pkg::ADDR_COMP_ONLY_PROG);

	// Writes accepted in any state; the host keeps them to normal mode
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wake_en_prog_q <= swcr_pkg::WAKE_EN_PROG_RST;
			wake_en_gnd_q <= swcr_pkg::WAKE_EN_GND_RST;
			comp_only_prog_q <= swcr_pkg::COMP_ONLY_PROG_RST;
		end else begin
			if (wr_wake_prog) begin
				wake_en_prog_q <= rx_q[7:0];
			end
			if (wr_wake_gnd) begin
				wake_en_gnd_q <= rx_q[13:0];
			end
			if (wr_comp_prog) begin
				comp_only_prog_q <= rx_q[7:0];
			end
		end
	end

	// Unused bits and unmapped addresses read as zero
	assign rd_data = (last_addr_q == swcr_pkg::ADDR_WAKE_EN_PROG) ? {14'h0000, wake_en_prog_q} :
		(last_addr_q == swcr_pkg::ADDR_WAKE_EN_GND) ? {8'h00, wake_en_gnd_q} :
		(last_addr_q == swcr_pkg::ADDR_COMP_ONLY_PROG) ? {14'h0000, comp_only_prog_q} :
		22'h000000;

	// ------------------------------------------------------------
	// Polling control
	// ------------------------------------------------------------
	logic any_wake_en;
	logic poll_event;

	assign any_wake_en = (|wake_en_prog_q) | (|wake_en_gnd_q);
	// Timer stops only in sleep with no wake-enable bit set; normal mode keeps it
	assign poll_timer_run_out = ~sleep_state_in | any_wake_en;
	assign poll_event = sleep_state_in & any_wake_en & poll_tick_in;
	assign poll_event_out = poll_event;
	// Comparator-only inputs never draw polling current
	assign poll_current_en_out = {8{poll_event}} & ~comp_only_prog_q;
	assign comparator_only_out = comp_only_prog_q;

	// ------------------------------------------------------------
	// Wake detection
	// ------------------------------------------------------------
	logic [7:0] prog_ref_q;
	logic [13:0] gnd_ref_q;
	logic [7:0] prog_look;
	logic [7:0] prog_armed;
	logic prog_wake;
	logic gnd_wake;
	logic wake_q;

	// Comparator-only inputs are checked every sleep tick, others at poll events
	assign prog_look = comp_only_prog_q & {8{sleep_tick_in}} | {8{poll_event}};
	assign prog_armed = wake_en_prog_q | comp_only_prog_q;
	assign prog_wake = |((prog_s ^ prog_ref_q) & prog_look & prog_armed);
	assign gnd_wake = |((gnd_s ^ gnd_ref_q) & {14{poll_event}} & wake_en_gnd_q);

	// References follow the pins while awake; in sleep only looked-at bits refresh
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prog_ref_q <= 8'h00;
			gnd_ref_q <= 14'h0000;
			wake_q <= 1'b0;
		end else begin
			if (!sleep_state_in) begin
				prog_ref_q <= prog_s;
				gnd_ref_q <= gnd_s;
			end else begin
				prog_ref_q <= (prog_s & prog_look) | (prog_ref_q & ~prog_look);
				if (poll_event) begin
					gnd_ref_q <= gnd_s;
				end
			end
			wake_q <= sleep_state_in & (prog_wake | gnd_wake);
		end
	end

	assign wake_out = wake_q;

endmodule : swcr_top

`default_nettype wire

// *** inc/swcr_pkg.sv ***
// Constants for the sleep/wake configuration register bank.
// Assumes a 32-bit serial frame, MSB first, from a host acting as bus master.
`default_nettype none

package swcr_pkg;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int FRAME_BITS = 32;
	localparam int ADDR_MSB = 31;
	localparam int ADDR_LSB = 25;
	localparam int RW_BIT = 24;
	localparam int FAULT_BIT = 23;
	localparam int FLAG_BIT = 22;
	localparam int RDATA_MSB = 21;
	localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
	localparam logic [5:0] BIT_CNT_MAX = 6'h3f;

	// ------------------------------------------------------------
	// Register addresses (7-bit frame address field)
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_WAKE_EN_PROG = 7'h10;
	localparam logic [6:0] ADDR_WAKE_EN_GND = 7'h11;
	localparam logic [6:0] ADDR_COMP_ONLY_PROG = 7'h12;

	// ------------------------------------------------------------
	// Field widths and power-on defaults
	// ------------------------------------------------------------
	localparam int PROG_W = 8;
	localparam int GND_W = 14;
	localparam logic [7:0] WAKE_EN_PROG_RST = 8'hff;
	localparam logic [13:0] WAKE_EN_GND_RST = 14'h3fff;
	localparam logic [7:0] COMP_ONLY_PROG_RST = 8'h00;

	// Pin synchroniser resets: chip select idles high, rest low
	localparam int PIN_W = 25;
	localparam logic [24:0] PIN_RST = 25'h0800000;

endpackage : swcr_pkg

`default_nettype wire

// *** rtl/swcr_sync.sv ***
// Three-stage synchroniser with a two-stage agreement filter, one per bit.
// Assumes inputs are asynchronous to clk_in; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none

module swcr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ------------------------------------------------------------
	// Per-bit chain
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic out_q;
			// Stage 1 feeds stage 2 only, to keep metastability contained
			always_ff @(posedge clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					s1_q <= RST[i];
					s2_q <= RST[i];
					s3_q <= RST[i];
					out_q <= RST[i];
				end else begin
					s1_q <= async_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						out_q <= s3_q;
					end
				end
			end
			assign sync_out[i] = out_q;
		end
	endgenerate

endmodule : swcr_sync

`default_nettype wire

// *** testbench/swcr_monitor.sv ***
// Port checker for the sleep/wake register bank.
// Assumes bind onto swcr_top, one clk_in domain.
`timescale 1ns/1ps
`default_nettype none
module swcr_monitor (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_miso_oe_n_out,
	input wire logic sleep_state_in,
	input wire logic sleep_tick_in,
	input wire logic poll_tick_in,
	input wire logic wake_out,
	input wire logic poll_timer_run_out,
	input wire logic poll_event_out,
	input wire logic [7:0] poll_current_en_out,
	input wire logic [7:0] comparator_only_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	sequence cs_idle; spi_cs_n_in [*8]; endsequence
	sequence cs_busy; !spi_cs_n_in [*8]; endsequence
	a_wake_cause: assert property (wake_out |-> $past(sleep_state_in && (poll_tick_in || sleep_tick_in)))
		else $error("wake without a tick in sleep");
	a_oe_idle: assert property (cs_idle |-> spi_miso_oe_n_out)
		else $error("data out driven while deselected");
	a_oe_busy: assert property (cs_busy |-> !spi_miso_oe_n_out)
		else $error("data out not driven while selected");
	a_comp_hold: assert property ($changed(comparator_only_out) |-> spi_cs_n_in)
		else $error("comparator-only setting changed mid frame");
	a_timer_awake: assert property (!sleep_state_in |-> poll_timer_run_out)
		else $error("poll timer stopped while awake");
	a_timer_stop: assert property (sleep_state_in && !poll_timer_run_out |-> !poll_event_out)
		else $error("poll event with timer stopped");
	a_event_cause: assert property (poll_event_out |-> sleep_state_in && poll_tick_in)
		else $error("poll event without tick in sleep");
	a_current_split: assert property (poll_current_en_out == ({8{poll_event_out}} & ~comparator_only_out))
		else $error("poll current on a comparator-only input");
endmodule : swcr_monitor
bind swcr_top swcr_monitor u_mon (.clk_in, .arst_n_in, .spi_cs_n_in, .spi_miso_oe_n_out, .sleep_state_in,
	.sleep_tick_in, .poll_tick_in, .wake_out, .poll_timer_run_out, .poll_event_out, .poll_current_en_out,
	.comparator_only_out);
`default_nettype wire

// *** testbench/swcr_host.sv ***
// Host model: serial master sending 32-bit mode-0 frames, MSB first.
// Assumes the device samples on the rising link clock and shifts on the falling one.
`timescale 1ns/1ps
`default_nettype none
module swcr_host (
	input wire logic spi_miso_in,
	output logic spi_clk_out,
	output logic spi_cs_n_out,
	output logic spi_mosi_out
);
	initial begin
		spi_clk_out = 1'h0;
		spi_cs_n_out = 1'h1;
		spi_mosi_out = 1'h0;
	end
	// Address, direction, data; the reply belongs to the previous frame
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		spi_cs_n_out = 1'h0;
		#32;
		for (int i = 31; i >= 0; i--) begin
			spi_mosi_out = tx[i];
			#32;
			spi_clk_out = 1'h1;
			rx[i] = spi_miso_in;
			#32;
			spi_clk_out = 1'h0;
		end
		#32;
		spi_cs_n_out = 1'h1;
		// Released line keeps no level
		spi_mosi_out = ~spi_mosi_out;
		#64;
	endtask : xfer
endmodule : swcr_host
`default_nettype wire

// *** testbench/swcr_top_test.sv ***
// Testbench for swcr_top: register access through the host model, then wake checks.
// Assumes swcr_host in place of the microcontroller and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
module swcr_top_test;
	localparam logic [6:0] WP = swcr_pkg::ADDR_WAKE_EN_PROG;
	localparam logic [6:0] WG = swcr_pkg::ADDR_WAKE_EN_GND;
	localparam logic [6:0] CP = swcr_pkg::ADDR_COMP_ONLY_PROG;
	logic clk_in = 1'h0;
	logic arst_n_in = 1'h0;
	logic fault = 1'h1;
	logic flag = 1'h0;
	logic sleep = 1'h0;
	logic stick = 1'h0;
	logic ptick = 1'h0;
	logic [21:0] pins = 22'h0;
	logic spi_clk, cs_n, mosi, miso, oe_n, wake, run, pev;
	logic [7:0] pcur, comp;
	logic [31:0] rx;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #2.5 clk_in = ~clk_in;
	swcr_host u_host (.spi_miso_in(miso), .spi_clk_out(spi_clk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi));
	swcr_top u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .spi_clk_in(spi_clk), .spi_cs_n_in(cs_n),
		.spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_n_out(oe_n), .fault_status_in(fault),
		.interrupt_flag_bit_in(flag), .sleep_state_in(sleep), .sleep_tick_in(stick), .poll_tick_in(ptick),
		.programmable_input_in(pins[7:0]), .ground_switch_input_in(pins[21:8]), .wake_out(wake),
		.poll_timer_run_out(run), .poll_event_out(pev), .poll_current_en_out(pcur), .comparator_only_out(comp));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [31:0] rep(input logic [6:0] a, input logic w, input logic [21:0] d);
		return {a, w, fault, flag, d};
	endfunction : rep
	// Frames start on the falling clock so no link pin ever moves on a sampling edge
	task automatic rw(input logic [6:0] a, input logic w, input logic [23:0] d, input logic [31:0] exp);
		@(negedge clk_in);
		u_host.xfer({a, w, d}, rx);
		check(rx, exp);
	endtask : rw
	// Flip pins in sleep, give one tick, then look at poll event and wake
	task automatic wt(input logic [21:0] flip, input logic st, input logic en, input logic wk, input logic [7:0] cur);
		@(posedge clk_in);
		sleep <= 1'h0;
		repeat (8) @(posedge clk_in);
		sleep <= 1'h1;
		pins <= pins ^ flip;
		repeat (8) @(posedge clk_in);
		stick <= st;
		ptick <= ~st;
		#1;
		check(32'(run), 32'(en));
		check(32'(pev), 32'(en & ~st));
		check(32'(pcur), 32'(cur));
		@(posedge clk_in);
		stick <= 1'h0;
		ptick <= 1'h0;
		#1;
		check(32'(wake), 32'(wk));
		@(posedge clk_in);
		sleep <= 1'h0;
	endtask : wt
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("wrong value at %0t: timeout", $time);
			results();
		end
	end
	initial begin
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'h1;
		repeat (8) @(posedge clk_in);
		rw(7'h0, 1'h0, 24'h0, 32'h0 | rep(7'h0, 1'h0, 22'h0));
		rw(WP, 1'h0, 24'h0, rep(7'h0, 1'h0, 22'h0));
		rw(WG, 1'h0, 24'h0, rep(WP, 1'h0, 22'hff));
		rw(CP, 1'h0, 24'h0, rep(WG, 1'h0, 22'h3fff));
		wt(22'h1, 1'h0, 1'h1, 1'h1, 8'hff);
		$display("reset values done");
		rw(WP, 1'h1, 24'hffff5a, rep(CP, 1'h0, 22'h0));
		rw(WG, 1'h1, 24'hffc003, rep(WP, 1'h1, 22'h5a));
		rw(CP, 1'h1, 24'hffff02, rep(WG, 1'h1, 22'h3));
		rw(7'h13, 1'h0, 24'h0, rep(CP, 1'h1, 22'h2));
		check(32'(comp), 32'h00000002);
		wt(22'h1, 1'h0, 1'h1, 1'h0, 8'hfd);
		wt(22'h100, 1'h0, 1'h1, 1'h1, 8'hfd);
		// Bit 1 is driven as a clean logic level, the only use comparator-only suits
		wt(22'h2, 1'h1, 1'h1, 1'h1, 8'h00);
		$display("register writes done");
		rw(WP, 1'h1, 24'h0, rep(7'h13, 1'h0, 22'h0));
		rw(WG, 1'h1, 24'h0, rep(WP, 1'h1, 22'h0));
		rw(CP, 1'h1, 24'h0, rep(WG, 1'h1, 22'h0));
		wt(22'h3ff, 1'h0, 1'h0, 1'h0, 8'h00);
		$display("wake tests done");
		rw(CP, 1'h0, 24'h0, rep(CP, 1'h1, 22'h0));
		// Mid-run reset must bring every register back to its default
		@(posedge clk_in);
		arst_n_in <= 1'h0;
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'h1;
		repeat (8) @(posedge clk_in);
		rw(WG, 1'h0, 24'h0, rep(7'h0, 1'h0, 22'h0));
		rw(WP, 1'h0, 24'h0, rep(WG, 1'h0, 22'h3fff));
		rw(CP, 1'h0, 24'h0, rep(WP, 1'h0, 22'hff));
		rw(7'h0, 1'h0, 24'h0, rep(CP, 1'h0, 22'h0));
		$display("reset restore done");
		results();
	end
endmodule : swcr_top_test
`default_nettype wire
